// *** shared/thermal_mon_pkg.sv ***
// constants, register map and state codes of the thermal threshold monitor
//
// Overview of operation
// - six warning levels, each flag, live, mask
// - warning level rising sets its latched flag
// - live bit releases five degrees below level
// - shutdown holds until cooled by configurable hysteresis
// - every comparator debounced ten microseconds both ways
// - monitor enable cleared switches monitor fully off
// - run with always-on keeps sensor powered
// - otherwise sensor powered 450 us per 3 ms, or continuously while shut down
// - standby samples while monitor enabled, unless shut down
// - shutdown trip level sits above highest warning
package thermal_mon_pkg;

	////////////////////////////////////////////////////////////////////////
	// clock and timing
	localparam int unsigned CLK_PERIOD_NS = 10;
	// debounce time, least time so rounded up
	localparam int unsigned T_DEBOUNCE_NS = 10000;
	localparam int unsigned DEBOUNCE_CYC =
		(T_DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// sampling interval and window
	localparam int unsigned T_SMP_INTERVAL_NS = 3000000;
	localparam int unsigned SMP_INTERVAL_CYC =
		T_SMP_INTERVAL_NS / CLK_PERIOD_NS;
	localparam int unsigned T_SMP_WINDOW_NS = 450000;
	localparam int unsigned SMP_WINDOW_CYC =
		(T_SMP_WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	////////////////////////////////////////////////////////////////////////
	// comparator set
	localparam int unsigned NUM_WARN = 6;
	// shutdown hysteresis choices in degrees, picked by a control bit
	localparam int unsigned SD_HYS_LOW_C = 10;
	localparam int unsigned SD_HYS_HIGH_C = 15;

	////////////////////////////////////////////////////////////////////////
	// register map, byte addresses
	localparam int unsigned ADDR_W = 5;
	localparam logic [4:0] REG_CTRL = 5'h00;
	localparam logic [4:0] REG_FLAG = 5'h04;
	localparam logic [4:0] REG_MASK = 5'h08;
	localparam logic [4:0] REG_SENSE = 5'h0c;
	localparam logic [4:0] REG_EVT = 5'h10;
	localparam logic [4:0] REG_EVT_MASK = 5'h14;
	// control fields
	localparam int unsigned CTRL_ON_BIT = 0;
	localparam int unsigned CTRL_AON_BIT = 1;
	localparam int unsigned CTRL_HYS_BIT = 2;
	// sense fields above the six live bits
	localparam int unsigned SENSE_SD_BIT = 6;
	localparam int unsigned SENSE_PWR_BIT = 7;
	// event fields
	localparam int unsigned EVT_W = 3;
	localparam int unsigned EVT_WARN_BIT = 0;
	localparam int unsigned EVT_SD_ON_BIT = 1;
	localparam int unsigned EVT_SD_OFF_BIT = 2;
	// reset values
	localparam logic RST_CTRL_ON = 1'h1;
	localparam logic RST_CTRL_AON = 1'h1;
	localparam logic RST_CTRL_HYS = 1'h1;
	localparam logic [5:0] RST_MASK = 6'h3f;
	localparam logic [2:0] RST_EVT_MASK = 3'h0;

	// sensor power states
	typedef enum logic [1:0]
	{
		PWR_OFF = 2'b00,
		PWR_CONT = 2'b01,
		PWR_WIN = 2'b10,
		PWR_IDLE = 2'b11
	} pwr_state_t;

endpackage

// *** design/comp_debounce.sv ***
// two-flop synchroniser and symmetric debounce filter for one comparator
`timescale 1ns/1ps
module comp_debounce
#(
	parameter int unsigned N = 1000
)
(
	// clock and reset
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	// raw comparator and count enable
	input wire logic raw_in,
	input wire logic run_in,
	// filtered level
	output logic stable_out
);
	localparam int unsigned CW = $clog2(N + 1);

	// whole state of the filter
	typedef struct packed
	{
		logic s1;
		logic s2;
		logic stable;
		logic [CW-1:0] cnt;
	} db_state_t;

	db_state_t st_ff;
	db_state_t nxt_st;

	////////////////////////////////////////////////////////////////////////
	// next state
	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.s1 = raw_in;
		// first flop only feeds the second
		nxt_st.s2 = st_ff.s1;
		if (!run_in || st_ff.s2 == st_ff.stable)
		begin
			// cleared while unpowered, restart on any bounce
			nxt_st.cnt = '0;
		end
		else if (st_ff.cnt == CW'(N - 1))
		begin
			// held long enough in the new direction
			nxt_st.stable = st_ff.s2;
			nxt_st.cnt = '0;
		end
		else
		begin
			nxt_st.cnt = st_ff.cnt + CW'(1);
		end
	end

	// state register
	always_ff @(posedge sys_clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	assign stable_out = st_ff.stable;

	////////////////////////////////////////////////////////////////////////
	// checks
	AST_DB_HOLD: assert property (@(posedge sys_clk_in)
		disable iff (sys_rst_in)
		$changed(st_ff.stable) |-> $past(st_ff.cnt) == CW'(N - 1)
		&& $past(st_ff.s2) == st_ff.stable)
	else $error("debounced level changed before hold time");

endmodule

// *** design/thermal_threshold_monitor.sv ***
// thermal threshold monitor: debounce, flags, shutdown, sensor duty cycle
//
// Decided for this implementation: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
module thermal_threshold_monitor
	import thermal_mon_pkg::*;
#(
	parameter int unsigned SMP_INT_CYC = SMP_INTERVAL_CYC,
	parameter int unsigned SMP_WIN_CYC = SMP_WINDOW_CYC
)
(
	// clock and reset
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	// avalon-mm slave
	input wire logic [thermal_mon_pkg::ADDR_W-1:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	// device power state
	input wire logic run_state_in,
	input wire logic standby_state_in,
	// analog comparators, asynchronous
	input wire logic [5:0] warn_trip_in,
	input wire logic [5:0] warn_release_in,
	input wire logic sd_trip_in,
	input wire logic sd_release_low_in,
	input wire logic sd_release_high_in,
	// analog control and system outputs
	output logic sensor_pwr_out,
	output logic shutdown_out,
	output logic int_n_out,
	output logic irq_out
);
	import thermal_mon_pkg::*;

	// interval counter sized to the interval; the window must be shorter
	// than the interval, or the sensor never powers down between samples
	localparam int unsigned CNT_W = $clog2(SMP_INT_CYC);
	localparam int unsigned NUM_CMP = 2 * NUM_WARN + 3;

	// whole state of the block
	typedef struct packed
	{
		logic waitreq;
		logic [31:0] rdata;
		logic thermal_monitor_on;
		logic thermal_always_powered;
		logic sd_hys_high;
		logic [5:0] flag;
		logic [5:0] mask;
		logic [5:0] live;
		logic sd;
		logic [EVT_W-1:0] evt;
		logic [EVT_W-1:0] evt_mask;
		pwr_state_t pstate;
		logic [CNT_W-1:0] cnt;
		logic pwr;
		logic int_n;
		logic irq;
	} mon_state_t;

	// reset image
	localparam mon_state_t ST_RST = '{
		waitreq: 1'b1,
		rdata: 32'h0,
		thermal_monitor_on: RST_CTRL_ON,
		thermal_always_powered: RST_CTRL_AON,
		sd_hys_high: RST_CTRL_HYS,
		flag: 6'h0,
		mask: RST_MASK,
		live: 6'h0,
		sd: 1'b0,
		evt: '0,
		evt_mask: RST_EVT_MASK,
		pstate: PWR_OFF,
		cnt: '0,
		pwr: 1'b0,
		int_n: 1'b1,
		irq: 1'b0
	};

	// registered state and its next value
	mon_state_t st_ff;
	mon_state_t nxt_st;

	// all comparators in one vector
	logic [NUM_CMP-1:0] raw_cmp;
	logic [NUM_CMP-1:0] db_cmp;
	// debounced views
	logic [5:0] db_trip;
	logic [5:0] db_rel;
	logic db_sd_trip;
	logic db_sd_rel;
	// bus decode, warning rises and sensor power terms
	logic wr_ack;
	logic rd_ack;
	logic [5:0] rise;
	logic mon_en;
	logic cont_pwr;

	////////////////////////////////////////////////////////////////////////
	// comparator filters, counted only while the sensor is powered
	// order matters: warning trips low, then releases, then shutdown trio
	assign raw_cmp = {sd_release_high_in, sd_release_low_in, sd_trip_in,
		warn_release_in, warn_trip_in};

	generate
		for (genvar g = 0; g < NUM_CMP; g++)
		begin : g_db
			comp_debounce #(.N(DEBOUNCE_CYC)) u_db
			(
				.sys_clk_in(sys_clk_in),
				.sys_rst_in(sys_rst_in),
				.raw_in(raw_cmp[g]),
				.run_in(st_ff.pwr),
				.stable_out(db_cmp[g])
			);
		end
	endgenerate

	// split filtered vector
	assign db_trip = db_cmp[5:0];
	assign db_rel = db_cmp[11:6];
	assign db_sd_trip = db_cmp[12];
	// releasing comparator picked by the hysteresis choice
	assign db_sd_rel = st_ff.sd_hys_high ? db_cmp[14] : db_cmp[13];

	////////////////////////////////////////////////////////////////////////
	// next state
	always_comb
	begin
		nxt_st = st_ff;
		// access completes in the cycle waitrequest is low
		wr_ack = avs_write_in & ~st_ff.waitreq & avs_byteenable_in[0];
		rd_ack = avs_read_in & ~st_ff.waitreq;
		// one wait state per access, then back high
		nxt_st.waitreq = ~((avs_read_in | avs_write_in) & st_ff.waitreq);

		// read data sampled as waitrequest drops
		if (avs_read_in && st_ff.waitreq)
		begin
			case (avs_address_in)
				REG_CTRL:
					nxt_st.rdata = {29'h0, st_ff.sd_hys_high,
						st_ff.thermal_always_powered,
						st_ff.thermal_monitor_on};
				REG_FLAG:
					nxt_st.rdata = {26'h0, st_ff.flag};
				REG_MASK:
					nxt_st.rdata = {26'h0, st_ff.mask};
				REG_SENSE:
					nxt_st.rdata = {24'h0, st_ff.pwr, st_ff.sd, st_ff.live};
				REG_EVT:
					nxt_st.rdata = {29'h0, st_ff.evt};
				REG_EVT_MASK:
					nxt_st.rdata = {29'h0, st_ff.evt_mask};
				default:
					nxt_st.rdata = 32'h0; // unmapped reads zero
			endcase
		end

		// control and mask writes
		if (wr_ack && avs_address_in == REG_CTRL)
		begin
			nxt_st.thermal_monitor_on = avs_writedata_in[CTRL_ON_BIT];
			nxt_st.thermal_always_powered = avs_writedata_in[CTRL_AON_BIT];
			nxt_st.sd_hys_high = avs_writedata_in[CTRL_HYS_BIT];
		end
		if (wr_ack && avs_address_in == REG_MASK)
			nxt_st.mask = avs_writedata_in[5:0];
		if (wr_ack && avs_address_in == REG_EVT_MASK)
			nxt_st.evt_mask = avs_writedata_in[EVT_W-1:0];

		// sensor power: off, continuous or sampled
		mon_en = st_ff.thermal_monitor_on
			& (run_state_in | standby_state_in);
		// standby ignores always-on; a tripped die stays watched
		cont_pwr = st_ff.sd | (run_state_in & ~standby_state_in
			& st_ff.thermal_always_powered);
		if (!mon_en)
		begin
			nxt_st.pstate = PWR_OFF;
			nxt_st.cnt = '0;
		end
		else if (cont_pwr)
		begin
			nxt_st.pstate = PWR_CONT;
			nxt_st.cnt = '0;
		end
		else
		begin
			case (st_ff.pstate)
				PWR_WIN, PWR_IDLE:
					if (st_ff.cnt == CNT_W'(SMP_INT_CYC - 1))
						nxt_st.cnt = '0;
					else
						nxt_st.cnt = st_ff.cnt + CNT_W'(1);
				default:
					nxt_st.cnt = '0; // new window starts at once
			endcase
			// powered for the first part of each interval
			if (nxt_st.cnt < CNT_W'(SMP_WIN_CYC))
				nxt_st.pstate = PWR_WIN;
			else
				nxt_st.pstate = PWR_IDLE;
		end
		nxt_st.pwr = (nxt_st.pstate == PWR_CONT)
			|| (nxt_st.pstate == PWR_WIN);

		// live bits set at level, held until the lower comparator drops
		for (int i = 0; i < NUM_WARN; i++)
		begin
			if (db_trip[i])
				nxt_st.live[i] = 1'b1;
			else if (!db_rel[i])
				nxt_st.live[i] = 1'b0;
		end
		rise = nxt_st.live & ~st_ff.live;

		// flags: write one clears, a new rise in that cycle wins
		if (wr_ack && avs_address_in == REG_FLAG)
			nxt_st.flag = st_ff.flag & ~avs_writedata_in[5:0];
		nxt_st.flag = nxt_st.flag | rise;

		// shutdown latch, the trip comparator sits above all warnings
		if (db_sd_trip)
			nxt_st.sd = 1'b1;
		else if (!db_sd_rel)
			nxt_st.sd = 1'b0;

		// system events: a read of the register clears, new events win
		if (rd_ack && avs_address_in == REG_EVT)
			nxt_st.evt = '0;
		nxt_st.evt[EVT_WARN_BIT] = nxt_st.evt[EVT_WARN_BIT] | (|rise);
		nxt_st.evt[EVT_SD_ON_BIT] = nxt_st.evt[EVT_SD_ON_BIT]
			| (nxt_st.sd & ~st_ff.sd);
		nxt_st.evt[EVT_SD_OFF_BIT] = nxt_st.evt[EVT_SD_OFF_BIT]
			| (~nxt_st.sd & st_ff.sd);

		// interrupt outputs follow the registered sources
		nxt_st.int_n = ~|(nxt_st.flag & ~nxt_st.mask);
		nxt_st.irq = |(nxt_st.evt & nxt_st.evt_mask);
	end

	////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge sys_clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
			st_ff <= ST_RST;
		else
			st_ff <= nxt_st;
	end

	// outputs straight from the state flops
	assign avs_readdata_out = st_ff.rdata;
	assign avs_waitrequest_out = st_ff.waitreq;
	assign sensor_pwr_out = st_ff.pwr;
	assign shutdown_out = st_ff.sd;
	assign int_n_out = st_ff.int_n;
	assign irq_out = st_ff.irq;

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (sys_rst_in);

	AST_FLAG_ON_RISE: assert property (
		(st_ff.live & ~$past(st_ff.live) & ~st_ff.flag) == 6'h0)
	else $error("live bit rose without its flag");

	// a live bit may only drop once its release comparator has dropped
	AST_LIVE_RELEASE: assert property (
		($past(st_ff.live) & ~st_ff.live & $past(db_rel)) == 6'h0)
	else $error("live bit released above hysteresis level");

	AST_SD_HOLD: assert property (
		$fell(shutdown_out) |-> !$past(db_sd_rel) && !$past(db_sd_trip))
	else $error("shutdown released before cooling");

	AST_SD_TRIP: assert property (
		$past(db_sd_trip) |-> shutdown_out)
	else $error("shutdown not taken at trip level");

	AST_MON_OFF: assert property (
		!st_ff.thermal_monitor_on |=> !sensor_pwr_out)
	else $error("sensor powered while monitor disabled");

	AST_AON_RUN: assert property (
		st_ff.thermal_monitor_on && st_ff.thermal_always_powered
		&& run_state_in && !standby_state_in |=> sensor_pwr_out)
	else $error("sensor not continuous in run with always-on");

	AST_WIN_LEN: assert property (
		$fell(sensor_pwr_out) && st_ff.pstate == PWR_IDLE
		|-> $past(st_ff.cnt) == CNT_W'(SMP_WIN_CYC - 1))
	else $error("sampling window length wrong");

	AST_STBY_SAMPLE: assert property (
		standby_state_in && !st_ff.sd && st_ff.thermal_monitor_on
		|=> st_ff.pstate inside {PWR_WIN, PWR_IDLE})
	else $error("standby monitor not in sampling mode");

	AST_INT_LEVEL: assert property (
		int_n_out == !(|(st_ff.flag & ~st_ff.mask)))
	else $error("interrupt pin disagrees with flags");

	AST_FLAG_W1C: assert property (
		wr_ack && avs_address_in == REG_FLAG && avs_writedata_in[0]
		&& !rise[0] |=> !st_ff.flag[0])
	else $error("flag not cleared by write one");

	// a flag only drops under a host write to the flag register
	AST_FLAG_STICKY: assert property (
		($past(st_ff.flag) & ~st_ff.flag) == 6'h0
		|| ($past(wr_ack) && $past(avs_address_in) == REG_FLAG))
	else $error("flag dropped without a clearing write");

	// every access answered after exactly one wait state
	AST_BUS_ANSWER: assert property (
		(avs_read_in || avs_write_in) && avs_waitrequest_out
		|=> !avs_waitrequest_out)
	else $error("bus access not answered after one wait state");

	// waitrequest low for a single cycle, so no access is taken twice
	AST_BUS_ONE_LOW: assert property (
		!avs_waitrequest_out |=> avs_waitrequest_out)
	else $error("waitrequest held low too long");

	// event interrupt follows the enabled sticky events
	AST_IRQ_LEVEL: assert property (
		irq_out == |(st_ff.evt & st_ff.evt_mask))
	else $error("event interrupt disagrees with events");

	COV_SD: cover property ($rose(shutdown_out));
	COV_FLAG: cover property ($rose(st_ff.flag[5]));
	COV_SAMPLE: cover property ($rose(sensor_pwr_out)
		&& $past(st_ff.pstate) == PWR_IDLE);
	COV_READ: cover property (rd_ack && avs_address_in == REG_EVT);

endmodule

// *** tb/comparator_model.sv ***
// behavioural model of the on-die analog threshold comparators
`timescale 1ns/1ps
module comparator_model
(
	// die temperature in degrees and sensor supply
	input wire integer temp_in,
	input wire logic pwr_in,
	// comparator outputs
	output logic [5:0] trip_out,
	output logic [5:0] rel_out,
	output logic sd_trip_out,
	output logic sd_lo_out,
	output logic sd_hi_out
);
	////////////////////////////////////////////////////////////////////////
	// unpowered comparators read low, so stale levels never leak through
	always_comb
	begin
		for (int k = 0; k < 6; k++)
		begin
			// six levels, 80 to 155 in steps of 15
			trip_out[k] = pwr_in && temp_in > 80 + 15 * k;
			// release sits 5 below, so trip implies release
			rel_out[k] = pwr_in && temp_in > 75 + 15 * k;
		end
		sd_trip_out = pwr_in && temp_in > 165;
		sd_lo_out = pwr_in && temp_in > 155;
		sd_hi_out = pwr_in && temp_in > 150;
	end
endmodule

// *** tb/thermal_threshold_monitor_tb.sv ***
// self-checking bench of the thermal threshold monitor
`timescale 1ns/1ps
module thermal_threshold_monitor_tb;
	import thermal_mon_pkg::*;
	logic clk, rst, rd, we, run, stby, pwr, sd, int_n, irq, wreq;
	logic sdt, sdl, sdh;
	logic [4:0] addr;
	logic [31:0] wdata, rdata, q;
	logic [5:0] trip, rel;
	int temp, n_mismatch, n_checks, cyc;
	////////////////////////////////////////////////////////////////////////
	// short sampling period keeps the run brief
	thermal_threshold_monitor #(.SMP_INT_CYC(300), .SMP_WIN_CYC(45))
		thermal_threshold_monitor_inst (.sys_clk_in(clk), .sys_rst_in(rst),
		.avs_address_in(addr), .avs_read_in(rd), .avs_write_in(we),
		.avs_writedata_in(wdata), .avs_byteenable_in(4'hf),
		.avs_readdata_out(rdata), .avs_waitrequest_out(wreq),
		.run_state_in(run), .standby_state_in(stby),
		.warn_trip_in(trip), .warn_release_in(rel), .sd_trip_in(sdt),
		.sd_release_low_in(sdl), .sd_release_high_in(sdh),
		.sensor_pwr_out(pwr), .shutdown_out(sd), .int_n_out(int_n),
		.irq_out(irq));
	comparator_model comparator_model_inst (.temp_in(temp), .pwr_in(pwr),
		.trip_out(trip), .rel_out(rel), .sd_trip_out(sdt),
		.sd_lo_out(sdl), .sd_hi_out(sdh));
	////////////////////////////////////////////////////////////////////////
	// clock, and a cycle ceiling against hangs
	initial
	begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			n_mismatch++;
			$display("ERROR %0t timeout", $time);
			give_verdict();
		end
	end
	////////////////////////////////////////////////////////////////////////
	// one bus access; a fresh edge first so strobes never retoggle at once
	task automatic bus(input logic w, input logic [4:0] a,
		input logic [31:0] d);
		@(posedge clk);
		rd <= !w;
		we <= w;
		addr <= a;
		wdata <= d;
		// request held until the rising edge that sees waitrequest low
		do @(posedge clk); while (wreq !== 1'b0);
		q = rdata;
		rd <= 0;
		we <= 0;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("ERROR %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic rchk(input logic [4:0] a, input logic [31:0] exp);
		bus(0, a, 0);
		chk(q, exp);
	endtask
	// temperature step, then a wait of n clock cycles
	task automatic heat(input int t, input int n);
		temp <= t;
		repeat (n) @(posedge clk);
	endtask
	// number of powered cycles over a span
	task automatic pcount(input int n, input int exp);
		logic [31:0] s;
		s = 0;
		repeat (n) @(negedge clk) s += pwr;
		chk(s, exp);
	endtask
	////////////////////////////////////////////////////////////////////////
	// reset values and an unmapped address
	task automatic t_reset();
		rchk(REG_CTRL, 32'h7);
		rchk(REG_MASK, 32'h3f);
		rchk(REG_FLAG, 32'h0);
		rchk(5'h1c, 32'h0);
		$display("test reset done");
	endtask
	// warning rise: flag, live, interrupt, event
	task automatic t_warn();
		bus(1, REG_EVT_MASK, 32'h1);
		heat(85, 980);
		rchk(REG_FLAG, 32'h0);
		heat(85, 40);
		rchk(REG_FLAG, 32'h1);
		rchk(REG_SENSE, 32'h81);
		chk(int_n, 1'b1);
		chk(irq, 1'b1);
		rchk(REG_EVT, 32'h1);
		// outputs launched at the answer edge settle by the falling edge
		@(negedge clk);
		chk(irq, 1'b0);
		bus(1, REG_MASK, 32'h3e);
		@(negedge clk);
		chk(int_n, 1'b0);
		bus(1, REG_FLAG, 32'h1);
		@(negedge clk);
		chk(int_n, 1'b1);
		rchk(REG_FLAG, 32'h0);
		$display("test warn done");
	endtask
	// short bounce ignored, release only 5 below the level
	task automatic t_hyst();
		heat(100, 500);
		heat(78, 1100);
		rchk(REG_FLAG, 32'h0);
		rchk(REG_SENSE, 32'h81);
		heat(74, 1100);
		rchk(REG_SENSE, 32'h80);
		$display("test hyst done");
	endtask
	// shutdown held at 152 with the high hysteresis, released at 154 with the low one
	task automatic t_sd();
		heat(170, 1100);
		chk(sd, 1'b1);
		rchk(REG_FLAG, 32'h3f);
		heat(152, 1100);
		chk(sd, 1'b1);
		heat(149, 1100);
		chk(sd, 1'b0);
		bus(1, REG_CTRL, 32'h3);
		heat(170, 1100);
		heat(154, 1100);
		chk(sd, 1'b0);
		heat(25, 1100);
		$display("test shutdown done");
	endtask
	// sensor duty cycle in each power mode
	task automatic t_pwr();
		pcount(300, 300);
		bus(1, REG_CTRL, 32'h5);
		// new mode takes over one edge after the write lands
		@(posedge clk);
		pcount(900, 135);
		bus(1, REG_CTRL, 32'h7);
		stby <= 1;
		repeat (2) @(posedge clk);
		pcount(900, 135);
		bus(1, REG_CTRL, 32'h6);
		@(posedge clk);
		pcount(100, 0);
		$display("test power done");
	endtask
	////////////////////////////////////////////////////////////////////////
	// counts and the verdict
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial
	begin
		rst = 1;
		rd = 0;
		we = 0;
		addr = 0;
		wdata = 0;
		run = 1;
		stby = 0;
		temp = 25;
		repeat (5) @(posedge clk);
		rst <= 0;
		t_reset();
		t_warn();
		t_hyst();
		t_sd();
		t_pwr();
		give_verdict();
	end
endmodule
